// >>> bench/ecp_periph_model.sv
// peripheral model for the ecp link: forward sink and reverse source
`timescale 1ns/1ps
module ecp_periph_model (
  input  wire logic       ref_clk,
  input  wire logic       slow,
  input  wire logic       stall,
  input  wire logic [7:0] pdOut,
  input  wire logic       strobe_n,
  input  wire logic       autoFd_n,
  input  wire logic       init_n,
  input  wire logic [7:0] revData,
  input  wire logic       revCmd,
  input  wire logic [7:0] revLimit,
  output logic      [7:0] pdIn,
  output logic            busy,
  output logic            ack_n,
  output logic            pError,
  output logic            select,
  output logic            rxValid,
  output logic      [7:0] rxData,
  output logic            rxCmd,
  output logic      [7:0] revCount
);
  logic tick;
  logic go;
  initial begin
    {tick, busy, pError, rxValid, rxCmd} = 5'h00;
    {ack_n, select} = 2'b11;
    pdIn = 8'h5A;
    rxData = 8'h00;
    revCount = 8'h00;
  end
  // slow mode only moves on every other edge
  assign go = !slow || tick;
  always @(posedge ref_clk) begin
    tick <= ~tick;
    rxValid <= 1'b0;
    pError <= init_n;
    if (init_n) begin
      ack_n <= 1'b1;
      pdIn <= ~pdIn;
      if (stall) busy <= 1'b1; // not ready, link must wait
      else if (go && !strobe_n && !busy) begin
        busy <= 1'b1;
        rxValid <= 1'b1;
        rxData <= pdOut;
        rxCmd <= !autoFd_n;
      end else if (go && strobe_n && busy) busy <= 1'b0;
    end else if (go && !autoFd_n && ack_n && !pError && revCount < revLimit) begin
      pdIn <= revData;
      busy <= !revCmd;
      ack_n <= 1'b0;
      revCount <= revCount + 8'h01;
    end else if (go && autoFd_n && !ack_n) ack_n <= 1'b1;
    else if (ack_n) pdIn <= ~pdIn; // released lines never hold the old byte
  end
endmodule : ecp_periph_model

// >>> bench/testbench.sv
// self-checking bench for the ecp parallel port block
`timescale 1ns/1ps
module testbench;
  import ecp_pkg::*;
  logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [12:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdv;
  logic pready, pslverr, irq, dmaReq, dmaAck = 0, dmaTc = 0, fault_n = 1, slow = 0, stall = 0;
  logic [7:0] dmaWrData = 0, dmaRdData, pdIn, pdOut, rxData, revCount, revLimit = 0, b;
  logic pdOe_n, strobe_n, autoFd_n, init_n, selectIn_n, busy, ack_n, pError, select;
  logic rxValid, rxCmd, er;
  logic [8:0] expQ[$];
  logic [8:0] e;
  int n_errors = 0, checks = 0;
  integer seed = 32'h1816;
  always #2 ref_clk = ~ref_clk;
  ecp_parallel_port_control i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .dmaReq(dmaReq), .dmaAck(dmaAck),
    .dmaTc(dmaTc), .dmaWrData(dmaWrData), .dmaRdData(dmaRdData), .pdIn(pdIn), .pdOut(pdOut),
    .pdOe_n(pdOe_n), .strobe_n(strobe_n), .autoFd_n(autoFd_n), .init_n(init_n),
    .selectIn_n(selectIn_n), .busy(busy), .ack_n(ack_n), .pError(pError), .select(select),
    .fault_n(fault_n));
  ecp_periph_model i_periph (.ref_clk(ref_clk), .slow(slow), .stall(stall), .pdOut(pdOut),
    .strobe_n(strobe_n), .autoFd_n(autoFd_n), .init_n(init_n), .revData(rev_byte(revCount)),
    .revCmd(revCount == 8'h03), .revLimit(revLimit), .pdIn(pdIn), .busy(busy), .ack_n(ack_n),
    .pError(pError), .select(select), .rxValid(rxValid), .rxData(rxData), .rxCmd(rxCmd),
    .revCount(revCount));
  function automatic logic [7:0] rev_byte(input logic [7:0] n);
    return 8'h3C ^ (n * 8'h1D);
  endfunction : rev_byte
  function automatic logic [12:0] ba(input logic [10:0] idx);
    return {idx, 2'b00};
  endfunction : ba
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) chk("pready", 1, 0);
    rdv = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input string nm, input logic [10:0] idx, input logic [31:0] ex);
    apb(1'b0, ba(idx), 32'h0);
    chk(nm, ex, rdv);
  endtask : rd_chk
  task automatic wait_irq(input int lim, input logic want, input string nm);
    logic seen;
    seen = 1'b0;
    repeat (lim) begin
      @(posedge ref_clk);
      if (irq === 1'b1) seen = 1'b1;
    end
    chk(nm, want, seen);
  endtask : wait_irq
  task automatic drain;
    int n;
    n = 0;
    while (expQ.size() != 0 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    chk("link drained", 0, expQ.size());
    repeat (8) @(posedge ref_clk);
  endtask : drain
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  always @(posedge ref_clk) begin
    if (rxValid === 1'b1) begin
      if (expQ.size() == 0) chk("unexpected link byte", 0, 1);
      else chk("link byte and tag", expQ.pop_front(), {rxCmd, rxData});
    end
  end
  initial begin
    #300000;
    chk("watchdog", 0, 1);
    finish_test();
  end
  initial begin
    repeat (11) @(posedge ref_clk);
    chk("reset outputs", 5'b11000, {strobe_n, autoFd_n, init_n, irq, dmaReq});
    @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd_chk("ecr reset", IDX_EXT_CONTROL, 32'h05);
    rd_chk("control reset", IDX_CONTROL, 32'hC0);
    rd_chk("status", IDX_STATUS, 32'hDF);
    apb(1'b1, ba(IDX_EXT_CONTROL), 32'hE4);
    rd_chk("config_a", IDX_FIFO, 32'h10);
    rd_chk("config_b", IDX_CONFIG_B, 32'h07);
    rd_chk("ecr in mode 111", IDX_EXT_CONTROL, 32'hE5);
    apb(1'b0, 13'h1010, 32'h0);
    chk("unmapped error", 1, er);
    chk("unmapped data", 0, rdv);
    $display("test registers done");
    apb(1'b1, ba(IDX_EXT_CONTROL), 32'h04);
    apb(1'b1, ba(IDX_CONTROL), 32'h04);
    apb(1'b1, ba(IDX_EXT_CONTROL), 32'h64);
    @(posedge ref_clk);
    chk("forward pins", 3'b110, {selectIn_n, init_n, pdOe_n});
    repeat (12) begin
      e = $random(seed);
      slow <= 1'($random(seed));
      expQ.push_back(e);
      apb(1'b1, e[8] ? ba(IDX_PORT_DATA) : ba(IDX_FIFO), {24'h0, e[7:0]});
    end
    drain();
    $display("test forward done");
    stall <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 17; i++) begin
      b = $random(seed);
      if (i < FIFO_DEPTH) expQ.push_back({1'b0, b});
      apb(1'b1, ba(IDX_FIFO), {24'h0, b});
    end
    rd_chk("ecr full", IDX_EXT_CONTROL, 32'h66);
    stall <= 1'b0;
    drain();
    rd_chk("ecr empty", IDX_EXT_CONTROL, 32'h65);
    $display("test fill done");
    apb(1'b1, ba(IDX_EXT_CONTROL), 32'h60);
    wait_irq(6, 1'b1, "free threshold irq");
    rd_chk("flag set", IDX_EXT_CONTROL, 32'h65);
    apb(1'b1, ba(IDX_EXT_CONTROL), 32'h64);
    wait_irq(8, 1'b0, "write one no irq");
    apb(1'b1, ba(IDX_EXT_CONTROL), 32'h6C);
    @(posedge ref_clk);
    chk("dma blocked by flag", 0, dmaReq);
    apb(1'b1, ba(IDX_EXT_CONTROL), 32'h68);
    @(posedge ref_clk);
    chk("dma request", 1, dmaReq);
    repeat (3) begin
      b = $random(seed);
      expQ.push_back({1'b0, b});
      dmaAck <= 1'b1; dmaWrData <= b;
      @(posedge ref_clk);
      dmaAck <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
    dmaTc <= 1'b1;
    @(posedge ref_clk);
    dmaTc <= 1'b0;
    wait_irq(4, 1'b1, "terminal count irq");
    chk("dma stopped", 0, dmaReq);
    drain();
    rd_chk("flag after tc", IDX_EXT_CONTROL, 32'h6D);
    apb(1'b1, ba(IDX_EXT_CONTROL), 32'h60);
    @(posedge ref_clk);
    chk("dma off", 0, dmaReq);
    wait_irq(6, 1'b1, "threshold again");
    $display("test service done");
    apb(1'b1, ba(IDX_EXT_CONTROL), 32'h74);
    fault_n <= 1'b0;
    wait_irq(8, 1'b0, "fault masked");
    fault_n <= 1'b1;
    apb(1'b1, ba(IDX_EXT_CONTROL), 32'h64);
    fault_n <= 1'b0;
    wait_irq(6, 1'b1, "fault edge irq");
    apb(1'b1, ba(IDX_EXT_CONTROL), 32'h74);
    apb(1'b1, ba(IDX_EXT_CONTROL), 32'h64);
    wait_irq(6, 1'b1, "fault unmask irq");
    fault_n <= 1'b1;
    $display("test fault done");
    apb(1'b1, ba(IDX_EXT_CONTROL), 32'h24);
    apb(1'b1, ba(IDX_CONTROL), 32'h20);
    revLimit <= 8'd10;
    slow <= 1'b1;
    apb(1'b1, ba(IDX_EXT_CONTROL), 32'h64);
    for (int n = 0; n < 2000 && revCount != 8'd10; n++) @(posedge ref_clk);
    repeat (10) @(posedge ref_clk);
    chk("reverse pins", 3'b011, {init_n, pdOe_n, selectIn_n});
    rd_chk("ecr reverse", IDX_EXT_CONTROL, 32'h64);
    apb(1'b1, ba(IDX_EXT_CONTROL), 32'h60);
    wait_irq(6, 1'b1, "fill threshold irq");
    for (int i = 0; i < 9; i++) rd_chk("reverse byte", IDX_FIFO, rev_byte(i));
    // last byte leaves by dma so the dma read path is seen
    apb(1'b1, ba(IDX_EXT_CONTROL), 32'h68);
    @(posedge ref_clk);
    chk("dma reverse request", 1, dmaReq);
    dmaAck <= 1'b1;
    @(posedge ref_clk);
    dmaAck <= 1'b0;
    @(posedge ref_clk);
    chk("dma read byte", rev_byte(8'd9), dmaRdData);
    rd_chk("ecr drained", IDX_EXT_CONTROL, 32'h69);
    $display("test reverse done");
    finish_test();
  end
endmodule : testbench

// >>> hw/ecp_parallel_port_control.sv
// ecp parallel port: apb registers, shared fifo, link handshake
// Behaviour
// RULE1: fault-irq-disable bit 4 set suppresses the fault edge interrupt.
// RULE2: bit 4 clear: pulse on fault fall, or on 1-to-0 write while fault low.
// RULE3: dma allow bit 3 permits dma requests; cleared blocks dma always.
// RULE4: service flag set blocks dma and service interrupts; clear arms one case.
// RULE5: hardware sets service flag on service event; software clears; writing 1 no irq.
// RULE6: with dma allowed, terminal count sets the service flag.
// RULE7: no dma, forward: free bytes at least free threshold sets service flag.
// RULE8: no dma, reverse: valid bytes at least fill threshold sets service flag.
// RULE9: read-only full flag bit 1 and empty flag bit 0 reflect the fifo.
// RULE10: all fifo port views share one sixteen byte fifo.
// RULE11: data, status, control and extended control reachable in every mode.
// RULE12: forward strobe presents byte on asserting edge, paced by busy.
// RULE13: reverse: peripheral asserts ack for valid data, handshakes with autofeed.
// RULE14: peripheral drops busy when ready; reverse busy high data, low command.
// RULE15: paper-error low acknowledges reverse; host drives data only when permitted.
// RULE16: forward autofeed high for data, low for command; reverse low requests byte.
// RULE17: fault raises error interrupt, forward only; may request reverse in ecp. Code raises it in reverse ecp too.
// RULE18: init driven low for reverse direction, high for forward.
// RULE19: select-in held deasserted in ecp mode.
// RULE20: software clears direction, strobe, autofeed, then writes mode 011.
// RULE21: address port bytes go out as commands, data port bytes as data.
// RULE22: mode lives in extended control bits 7..5; 011 selects ecp.
// RULE23: terminal count sets service flag, raises interrupt, stops dma.
// RULE24: software changes direction only in ps/2 mode.
// RULE25: each fifo entry carries a command tag steering autofeed on send.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module ecp_parallel_port_control
  import ecp_pkg::*;
#(
  parameter int DEPTH  = ecp_pkg::FIFO_DEPTH,
  parameter int ADDR_W = 13
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  output logic                   dmaReq,
  input  wire logic              dmaAck,
  input  wire logic              dmaTc,
  input  wire logic [7:0]        dmaWrData,
  output logic      [7:0]        dmaRdData,
  input  wire logic [7:0]        pdIn,
  output logic      [7:0]        pdOut,
  output logic                   pdOe_n,
  output logic                   strobe_n,
  output logic                   autoFd_n,
  output logic                   init_n,
  output logic                   selectIn_n,
  input  wire logic              busy,
  input  wire logic              ack_n,
  input  wire logic              pError,
  input  wire logic              select,
  input  wire logic              fault_n
);
  import ecp_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  typedef struct packed {
    logic [2:0]             mode;
    logic                   faultDis;
    logic                   dmaAllow;
    logic                   svcFlag;
    logic [5:0]             ctrl;
    logic [7:0]             data;
    logic [2:0]             cfgIrq;
    logic [3:0]             thrFree;
    logic [3:0]             thrFill;
    logic [DEPTH-1:0][8:0]  mem;
    logic [AW-1:0]          wp;
    logic [AW-1:0]          rp;
    logic [CW-1:0]          cnt;
    ecp_hs_t                hs;
    logic [7:0]             sendByte;
    logic                   sendCmd;
    logic                   faultPrev;
    logic                   ackPrev;
    logic                   irq;
    logic [31:0]            rdData;
    logic [7:0]             dmaRd;
  } ecp_state_t;

  ecp_state_t st;
  ecp_state_t n;
  logic [1:0] rstPipe;
  logic       rstSync;

  // fifo-backed modes, decoded more than once, and mapped indices
  function automatic logic isFifoMode(input logic [2:0] m);
    return (m == MODE_FIFO) || (m == MODE_ECP) || (m == MODE_TEST);
  endfunction : isFifoMode

  function automatic logic isMapped(input logic [10:0] i);
    return (i == IDX_PORT_DATA) || (i == IDX_STATUS) || (i == IDX_CONTROL) ||
           (i == IDX_FIFO) || (i == IDX_CONFIG_B) || (i == IDX_EXT_CONTROL) ||
           (i == IDX_THRESHOLD);
  endfunction : isMapped

  logic [10:0]   idx;
  logic          apbSetup;
  logic          apbWr;
  logic          apbRd;
  logic          dirRev;
  logic          fifoFull;
  logic          fifoEmpty;
  logic [CW-1:0] freeCnt;
  logic [8:0]    head;
  logic          engineOn;
  logic          ecpMode;
  logic          faultFall;
  logic          doPush;
  logic          doPop;
  logic [8:0]    pushWord;
  logic          svcSet;
  logic          faultIrq;

  assign idx       = paddr[ADDR_W-1:2];
  assign apbSetup  = psel && !penable;
  assign apbWr     = psel && penable && pwrite;
  assign apbRd     = psel && penable && !pwrite;
  assign ecpMode   = (st.mode == MODE_ECP);
  // direction bit is ignored in spp and fifo modes
  assign dirRev    = st.ctrl[CTL_DIRECTION] && (st.mode != MODE_SPP) && (st.mode != MODE_FIFO);
  assign fifoFull  = (st.cnt == CW'(DEPTH)); // see RULE9
  assign fifoEmpty = (st.cnt == '0); // see RULE9
  assign freeCnt   = CW'(DEPTH) - st.cnt;
  assign head      = st.mem[st.rp];
  assign engineOn  = (st.mode == MODE_FIFO) || ecpMode;
  assign faultFall = st.faultPrev && !fault_n;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync = rstPipe[1];

  always_comb begin
    n        = st;
    n.irq    = 1'b0;
    doPush   = 1'b0;
    doPop    = 1'b0;
    pushWord = 9'h000;
    svcSet   = 1'b0;
    faultIrq = 1'b0;
    n.faultPrev = fault_n;
    n.ackPrev   = ack_n;

    // read data captured in setup so prdata comes from a flop
    if (apbSetup && !pwrite) begin
      case (idx)
        IDX_PORT_DATA:   n.rdData = {24'h0, (st.mode == MODE_PS2) ? pdIn : st.data};
        IDX_STATUS:      n.rdData = {24'h0, ~busy, ack_n, pError, select, fault_n, 3'h7};
        IDX_CONTROL:     n.rdData = {24'h0, 2'h3, st.ctrl};
        IDX_FIFO: begin
          if (st.mode == MODE_CFG) begin
            n.rdData = {24'h0, CONFIG_A_VALUE};
          end else if (isFifoMode(st.mode) && !fifoEmpty) begin
            n.rdData = {24'h0, head[7:0]};
          end else begin
            n.rdData = 32'h0;
          end
        end
        IDX_CONFIG_B:    n.rdData = {24'h0, 1'b0, st.irq, st.cfgIrq, 3'h7};
        IDX_EXT_CONTROL: n.rdData = {24'h0, st.mode, st.faultDis, st.dmaAllow, st.svcFlag,
                                     fifoFull, fifoEmpty}; // see RULE11
        IDX_THRESHOLD:   n.rdData = {24'h0, st.thrFill, st.thrFree};
        default:         n.rdData = 32'h0;
      endcase
    end

    // register writes, taken at the access edge
    if (apbWr) begin
      case (idx)
        IDX_PORT_DATA: begin
          if (ecpMode && !dirRev) begin
            doPush   = 1'b1;
            pushWord = {1'b1, pwdata[7:0]}; // see RULE21
          end else begin
            n.data = pwdata[7:0];
          end
        end
        IDX_CONTROL:   n.ctrl = pwdata[5:0];
        IDX_FIFO: begin
          if (isFifoMode(st.mode) && !(ecpMode && dirRev)) begin
            doPush   = 1'b1;
            pushWord = {1'b0, pwdata[7:0]}; // see RULE10
          end
        end
        IDX_CONFIG_B:  n.cfgIrq = pwdata[5:3];
        IDX_EXT_CONTROL: begin
          n.mode     = pwdata[7:ECR_MODE_LSB]; // see RULE22
          n.faultDis = pwdata[ECR_FAULT_DIS];
          n.dmaAllow = pwdata[ECR_DMA_ALLOW];
          n.svcFlag  = pwdata[ECR_SVC_FLAG]; // see RULE5
          if (ecpMode && st.faultDis && !pwdata[ECR_FAULT_DIS] && !fault_n) begin
            faultIrq = 1'b1; // see RULE2
          end
        end
        IDX_THRESHOLD: begin
          n.thrFree = pwdata[3:0];
          n.thrFill = pwdata[7:4];
        end
        default: ;
      endcase
    end

    // host reads drain the fifo only in reverse ecp or test mode
    if (apbRd && (idx == IDX_FIFO) && ((ecpMode && dirRev) || (st.mode == MODE_TEST))) begin
      doPop = 1'b1;
    end

    // dma strobe moves one byte; cpu write wins a same-cycle collision
    if (dmaAck && dmaReq) begin
      if (dirRev) begin
        doPop   = 1'b1;
        n.dmaRd = head[7:0];
      end else if (!doPush) begin
        doPush   = 1'b1;
        pushWord = {1'b0, dmaWrData};
      end
    end

    // link handshake engine
    case (st.hs)
      HS_IDLE: begin
        if (engineOn && !dirRev && !fifoEmpty && !busy && (!ecpMode || pError)) begin
          n.sendByte = head[7:0];
          n.sendCmd  = head[8] && ecpMode; // see RULE25
          doPop      = 1'b1;
          n.hs       = HS_SETUP;
        end else if (ecpMode && dirRev && !fifoFull && !pError) begin
          n.hs = HS_RREQ; // see RULE15
        end
      end
      HS_SETUP: n.hs = HS_STB;
      HS_STB: begin
        if (busy) begin
          n.hs = HS_REL; // see RULE12
        end
      end
      HS_REL: begin
        if (!busy) begin
          n.hs = HS_IDLE;
        end
      end
      HS_RREQ: begin
        if (!ack_n) begin
          doPush   = 1'b1;
          pushWord = {~busy, pdIn}; // see RULE14
          n.hs     = HS_RREL;
        end
      end
      HS_RREL: begin
        if (ack_n) begin
          n.hs = HS_IDLE;
        end
      end
      default: n.hs = HS_IDLE;
    endcase
    if (!engineOn) begin
      n.hs = HS_IDLE;
    end

    // fifo pointers; overflow and underflow attempts are dropped
    if (doPush && !fifoFull) begin
      n.mem[st.wp] = pushWord;
      n.wp         = st.wp + 1'b1;
    end
    if (doPop && !fifoEmpty) begin
      n.rp = st.rp + 1'b1;
    end
    n.cnt = st.cnt + {{AW{1'b0}}, (doPush && !fifoFull)}
                   - {{AW{1'b0}}, (doPop && !fifoEmpty)};
    if (st.mode == MODE_SPP) begin
      n.wp  = '0;
      n.rp  = '0;
      n.cnt = '0;
    end

    // service events; hardware set wins over a same-cycle software clear
    if (!st.svcFlag) begin // see RULE4
      if (st.dmaAllow) begin
        svcSet = dmaTc; // see RULE6
      end else if (!dirRev) begin
        svcSet = (freeCnt >= CW'(st.thrFree)); // see RULE7
      end else begin
        svcSet = (st.cnt >= CW'(st.thrFill)); // see RULE8
      end
    end
    if (svcSet) begin
      n.svcFlag = 1'b1; // see RULE23
    end

    if (ecpMode && !st.faultDis && faultFall) begin
      faultIrq = 1'b1; // see RULE1
    end
    n.irq = svcSet || faultIrq || (st.ctrl[CTL_ACK_IRQ] && !st.ackPrev && ack_n); // see RULE17
  end

  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      st           <= '0;
      st.mode      <= ECR_MODE_RST;
      st.faultDis  <= ECR_FAULT_DIS_RST;
      st.dmaAllow  <= ECR_DMA_ALLOW_RST;
      st.svcFlag   <= ECR_SVC_FLAG_RST;
      st.ctrl      <= CTL_RST;
      st.data      <= DATA_RST;
      st.cfgIrq    <= CFG_IRQ_RST;
      st.thrFree   <= THR_FREE_RST;
      st.thrFill   <= THR_FILL_RST;
      st.hs        <= HS_IDLE;
      st.faultPrev <= 1'b1;
      st.ackPrev   <= 1'b1;
    end else begin
      st <= n;
    end
  end

  // bus answers in the first access cycle
  assign prdata    = st.rdData;
  assign pready    = psel && penable;
  assign pslverr   = psel && penable && !isMapped(idx);
  assign irq       = st.irq;
  assign dmaRdData = st.dmaRd;
  assign dmaReq    = st.dmaAllow && !st.svcFlag && isFifoMode(st.mode) &&
                     (dirRev ? !fifoEmpty : !fifoFull); // see RULE3

  // pins: engine owns strobe in fifo and ecp modes, autofeed in ecp mode only
  assign pdOut      = engineOn ? st.sendByte : st.data;
  // in ecp mode never drive the bus while the peripheral holds reverse acknowledge low
  assign pdOe_n     = dirRev || (ecpMode && !pError);
  assign strobe_n   = engineOn ? (st.hs != HS_STB) : !st.ctrl[CTL_STROBE];
  assign autoFd_n   = ecpMode ? (dirRev ? (st.hs != HS_RREQ) : !st.sendCmd) // see RULE16
                              : !st.ctrl[CTL_AUTOFD];
  assign init_n     = ecpMode ? !dirRev : st.ctrl[CTL_INIT]; // see RULE18
  assign selectIn_n = ecpMode ? 1'b1 : !st.ctrl[CTL_SELECTIN]; // see RULE19

  a_fault_masked: assert property (@(posedge ref_clk) disable iff (!rstSync) // see RULE1
    (ecpMode && st.faultDis && faultFall && !svcSet && !st.ctrl[CTL_ACK_IRQ] &&
     !(apbWr && idx == IDX_EXT_CONTROL)) |=> !irq)
    else $error("fault edge raised irq while disabled");
  a_fault_edge: assert property (@(posedge ref_clk) disable iff (!rstSync) // see RULE2
    (ecpMode && !st.faultDis && faultFall) |=> irq)
    else $error("fault edge did not raise irq");
  a_dma_blocked: assert property (@(posedge ref_clk) disable iff (!rstSync) // see RULE3
    !st.dmaAllow |-> !dmaReq)
    else $error("dma request while dma disallowed");
  a_svc_blocks: assert property (@(posedge ref_clk) disable iff (!rstSync) // see RULE4
    st.svcFlag |-> (!dmaReq && !svcSet))
    else $error("service flag did not block dma or service");
  a_svc_sticky: assert property (@(posedge ref_clk) disable iff (!rstSync) // see RULE5
    (st.svcFlag && !(apbWr && idx == IDX_EXT_CONTROL)) |=> st.svcFlag)
    else $error("service flag cleared without software");
  a_tc_sets: assert property (@(posedge ref_clk) disable iff (!rstSync) // see RULE6
    (!st.svcFlag && st.dmaAllow && dmaTc) |=> (st.svcFlag && irq && !dmaReq))
    else $error("terminal count did not set service flag");
  a_free_sets: assert property (@(posedge ref_clk) disable iff (!rstSync) // see RULE7
    (!st.svcFlag && !st.dmaAllow && !dirRev && freeCnt >= CW'(st.thrFree)) |=> st.svcFlag)
    else $error("free threshold did not set service flag");
  a_fill_sets: assert property (@(posedge ref_clk) disable iff (!rstSync) // see RULE8
    (!st.svcFlag && !st.dmaAllow && dirRev && st.cnt >= CW'(st.thrFill)) |=> st.svcFlag)
    else $error("fill threshold did not set service flag");
  a_strobe_pace: assert property (@(posedge ref_clk) disable iff (!rstSync) // see RULE12
    (st.hs == HS_SETUP) |=> (!strobe_n throughout (st.hs == HS_STB)))
    else $error("strobe not asserted after setup");
  a_init_select: assert property (@(posedge ref_clk) disable iff (!rstSync) // see RULE19
    ecpMode |-> (selectIn_n && (init_n == !dirRev)))
    else $error("select-in or init wrong in ecp mode");
endmodule : ecp_parallel_port_control

// >>> hw/ecp_pkg.sv
// shared constants and types for the ecp parallel port block
package ecp_pkg;
  // register indices; byte address is four times the index
  localparam logic [10:0] IDX_PORT_DATA   = 11'h000;
  localparam logic [10:0] IDX_STATUS      = 11'h001;
  localparam logic [10:0] IDX_CONTROL     = 11'h002;
  localparam logic [10:0] IDX_FIFO        = 11'h400;
  localparam logic [10:0] IDX_CONFIG_B    = 11'h401;
  localparam logic [10:0] IDX_EXT_CONTROL = 11'h402;
  localparam logic [10:0] IDX_THRESHOLD   = 11'h403;
  // port modes, extended control bits 7..5
  localparam logic [2:0] MODE_SPP  = 3'h0;
  localparam logic [2:0] MODE_PS2  = 3'h1;
  localparam logic [2:0] MODE_FIFO = 3'h2;
  localparam logic [2:0] MODE_ECP  = 3'h3;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CFG  = 3'h7;
  // extended control field positions
  localparam int ECR_MODE_LSB  = 5;
  localparam int ECR_FAULT_DIS = 4;
  localparam int ECR_DMA_ALLOW = 3;
  localparam int ECR_SVC_FLAG  = 2;
  localparam int ECR_FULL      = 1;
  localparam int ECR_EMPTY     = 0;
  // port control field positions
  localparam int CTL_STROBE    = 0;
  localparam int CTL_AUTOFD    = 1;
  localparam int CTL_INIT      = 2;
  localparam int CTL_SELECTIN  = 3;
  localparam int CTL_ACK_IRQ   = 4;
  localparam int CTL_DIRECTION = 5;
  // reset values
  localparam logic [2:0] ECR_MODE_RST      = 3'h0;
  localparam logic       ECR_FAULT_DIS_RST = 1'b0;
  localparam logic       ECR_DMA_ALLOW_RST = 1'b0;
  localparam logic       ECR_SVC_FLAG_RST  = 1'b1;
  localparam logic [5:0] CTL_RST           = 6'h00;
  localparam logic [7:0] DATA_RST          = 8'h00;
  localparam logic [2:0] CFG_IRQ_RST       = 3'h0;
  localparam logic [3:0] THR_FREE_RST      = 4'h8;
  localparam logic [3:0] THR_FILL_RST      = 4'h8;
  localparam logic [7:0] CONFIG_A_VALUE    = 8'h10;
  localparam int         FIFO_DEPTH        = 16;
  // link handshake states
  typedef enum logic [2:0] {
    HS_IDLE  = 3'b000,
    HS_SETUP = 3'b001,
    HS_STB   = 3'b010,
    HS_REL   = 3'b011,
    HS_RREQ  = 3'b100,
    HS_RREL  = 3'b101
  } ecp_hs_t;
endpackage : ecp_pkg
